// File: hw/dsc_cfg.svh
// constants for the debug stop control block: offsets, fields, resets
// assumes a wishbone slave with 32-bit data and byte addresses
// Behaviour
// - debug link uses two port pins only
// - disable bit frees data pin for gpio
// - enabled and attached: debugger owns data pin
// - core_flag_a under debug freezes timer peripherals
// - core_flag_a under debug freezes comm peripherals
// - link inoperative in deep sleep
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// ****************************************************************
// register map
// ****************************************************************
`define DSC_ADR_W 8
`define DSC_CTRL_OFF 8'h00
`define DSC_STAT_OFF 8'h04
`define DSC_CTRL_RST 32'h00000000
`define DSC_CTRL_MASK 32'h01000003

// ****************************************************************
// field positions
// ****************************************************************
`define DSC_SWD_DISABLE_BIT 24
`define DSC_TFRZ_BIT 0
`define DSC_CFRZ_BIT 1
`define DSC_ST_LINK_BIT 0
`define DSC_ST_ATT_BIT 1
`define DSC_ST_TFRZ_BIT 2
`define DSC_ST_CFRZ_BIT 3
`define DSC_ST_CLK_BIT 4

// ****************************************************************
// pins and sampling
// ****************************************************************
`define DSC_SWD_PINS 2
`define DSC_SYNC_STAGES 3

`endif

// File: hw/dsc_pkg.sv
// types shared by the debug stop control block
// assumes dsc_cfg.svh is on the include path
`default_nettype none
`include "dsc_cfg.svh"

package dsc_pkg;

  // ****************************************************************
  // bus request carrier
  // ****************************************************************
  typedef struct packed {
    logic [`DSC_ADR_W-1:0] adr; // byte address
    logic [31:0] dat;           // write data
    logic [3:0] sel;            // byte lanes
    logic we;                   // write when high
  } dsc_wb_req_t;

  // freeze requests toward peripheral groups
  typedef struct packed {
    logic timer; // timer-class stop
    logic comm;  // comm-class stop
  } dsc_freeze_t;

  // bus answer state
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } dsc_bus_st_t;

  // link state
  typedef enum logic [1:0] {
    LNK_OFF,
    LNK_IDLE,
    LNK_RUN
  } dsc_lnk_st_t;

endpackage : dsc_pkg

`default_nettype wire

// File: hw/dsc_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
// assumes pin is asynchronous to mclk
`default_nettype none

module dsc_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  // ****************************************************************
  // sampling chain
  // ****************************************************************
  logic [2:0] stg_ff;   // stage 0 is read only by stage 1
  logic [2:0] nxt_stg;
  logic lvl_ff;         // filtered level
  logic nxt_lvl;
  logic rise_ff;
  logic nxt_rise;
  logic fall_ff;
  logic nxt_fall;

  // next values: a change counts once stages 1 and 2 agree
  always_comb begin
    nxt_stg = {stg_ff[1:0], pin};
    nxt_lvl = lvl_ff;
    nxt_rise = 1'h0;
    nxt_fall = 1'h0;
    if (stg_ff[1] == stg_ff[2] && stg_ff[2] != lvl_ff) begin
      nxt_lvl = stg_ff[2];
      nxt_rise = stg_ff[2];
      nxt_fall = ~stg_ff[2];
    end
  end

  // registers only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stg_ff <= 3'h0;
      lvl_ff <= 1'h0;
      rise_ff <= 1'h0;
      fall_ff <= 1'h0;
    end else begin
      stg_ff <= nxt_stg;
      lvl_ff <= nxt_lvl;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  assign level = lvl_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;

endmodule : dsc_sync

`default_nettype wire

// File: hw/dsc_top.sv
// debug stop control: swd pin ownership, port disable, freeze outputs
// assumes a debug core on mclk that decodes the serial protocol, a
// port block that drives the data pin as gpio, and a wishbone master
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`default_nettype none
`include "dsc_cfg.svh"

module dsc_top
  import dsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire dsc_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial clock pin, port 13 bit 7, input only
  input wire logic swclk_pin,
  // serial data pin, port 4 bit 0, three signals
  input wire logic swdio_in,
  output logic swdio_out,
  output logic swdio_oe_n,
  // debug core side
  input wire logic dbg_attached,
  input wire logic dbg_dio_out,
  input wire logic dbg_dio_drive,
  output logic dbg_clk_rise,
  output logic dbg_clk_fall,
  output logic dbg_dio_in,
  output logic dbg_link_en,
  // gpio side of the data pin
  input wire logic gpio_out,
  input wire logic gpio_drive,
  output logic gpio_in,
  // core and power state
  input wire logic core_flag_a,
  input wire logic deep_sleep,
  // freeze toward peripheral groups
  output dsc_freeze_t freeze_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // word hit on a register offset
  function automatic logic adr_hit(
    input logic [`DSC_ADR_W-1:0] adr,
    input logic [`DSC_ADR_W-1:0] off
  );
    adr_hit = (adr[`DSC_ADR_W-1:2] == off[`DSC_ADR_W-1:2]);
  endfunction : adr_hit

  // merge write data into a word under byte enables
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction : lane_merge

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  logic clk_lvl;  // filtered serial clock level
  logic clk_rise; // one-cycle edge pulses
  logic clk_fall;
  logic dio_lvl;  // filtered data pin level

  dsc_sync u_clk_sync (
    .mclk(mclk),
    .rst(rst),
    .pin(swclk_pin),
    .level(clk_lvl),
    .rise(clk_rise),
    .fall(clk_fall)
  );

  dsc_sync u_dio_sync (
    .mclk(mclk),
    .rst(rst),
    .pin(swdio_in),
    .level(dio_lvl),
    .rise(),
    .fall()
  );

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [31:0] ctrl_ff;  // control word, spare bits held zero
  logic [31:0] nxt_ctrl;
  logic [31:0] rdat_ff;  // registered read data
  logic [31:0] nxt_rdat;
  dsc_bus_st_t bus_ff;   // answer state
  dsc_bus_st_t nxt_bus;
  logic [31:0] stat_w;   // live status word
  logic req_w;           // new request this cycle

  // field views of the control word
  logic swd_disable;
  logic timer_freeze_enable;
  logic comm_freeze_enable;
  assign swd_disable = ctrl_ff[`DSC_SWD_DISABLE_BIT];
  assign timer_freeze_enable = ctrl_ff[`DSC_TFRZ_BIT];
  assign comm_freeze_enable = ctrl_ff[`DSC_CFRZ_BIT];

  // a request is taken only when no answer is standing
  assign req_w = wb_cyc_i & wb_stb_i & (bus_ff == BUS_IDLE);

  // next values for bus and control
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rdat = rdat_ff;
    nxt_bus = BUS_IDLE;
    case (bus_ff)
      BUS_IDLE: begin
        if (req_w) begin
          nxt_bus = BUS_ACK;
          nxt_rdat = 32'h00000000;
          if (wb_req_i.we) begin
            if (adr_hit(wb_req_i.adr, `DSC_CTRL_OFF)) begin
              nxt_ctrl = lane_merge(ctrl_ff, wb_req_i.dat,
                wb_req_i.sel) & `DSC_CTRL_MASK;
            end
          end else if (adr_hit(wb_req_i.adr, `DSC_CTRL_OFF)) begin
            nxt_rdat = ctrl_ff & `DSC_CTRL_MASK;
          end else if (adr_hit(wb_req_i.adr, `DSC_STAT_OFF)) begin
            nxt_rdat = stat_w;
          end
        end
      end
      BUS_ACK: begin
        // ack stands one cycle, then the master must drop stb
        nxt_bus = BUS_IDLE;
      end
      default: begin
        nxt_bus = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `DSC_CTRL_RST;
      rdat_ff <= 32'h00000000;
      bus_ff <= BUS_IDLE;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rdat_ff <= nxt_rdat;
      bus_ff <= nxt_bus;
    end
  end

  assign wb_ack_o = (bus_ff == BUS_ACK);
  assign wb_dat_o = rdat_ff;

  // ****************************************************************
  // link state
  // ****************************************************************
  dsc_lnk_st_t lnk_ff;  // off, idle or running
  dsc_lnk_st_t nxt_lnk;
  logic link_en;        // port enabled and not in deep sleep
  logic owned;          // debugger owns the data pin

  // link off when disabled or in deep sleep
  assign link_en = ~swd_disable & ~deep_sleep;

  // next link state
  always_comb begin
    nxt_lnk = lnk_ff;
    case (lnk_ff)
      LNK_OFF: begin
        if (link_en) begin
          nxt_lnk = LNK_IDLE;
        end
      end
      LNK_IDLE: begin
        if (!link_en) begin
          nxt_lnk = LNK_OFF;
        end else if (dbg_attached) begin
          nxt_lnk = LNK_RUN;
        end
      end
      LNK_RUN: begin
        if (!link_en) begin
          nxt_lnk = LNK_OFF;
        end else if (!dbg_attached) begin
          nxt_lnk = LNK_IDLE;
        end
      end
      default: begin
        nxt_lnk = LNK_OFF;
      end
    endcase
  end

  // register the link state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lnk_ff <= LNK_OFF;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // attached and enabled: debugger owns the pin
  assign owned = (lnk_ff == LNK_RUN) & link_en;

  // ****************************************************************
  // pin mux and debug core feed
  // ****************************************************************
  logic dio_out_ff;  // registered pin data
  logic nxt_dio_out;
  logic oe_n_ff;     // registered enable, low drives
  logic nxt_oe_n;
  logic crise_ff;    // gated edge pulses to the debug core
  logic nxt_crise;
  logic cfall_ff;
  logic nxt_cfall;

  // next pin drive and core feed
  always_comb begin
    if (owned) begin
      nxt_dio_out = dbg_dio_out;
      nxt_oe_n = ~dbg_dio_drive;
    end else begin
      nxt_dio_out = gpio_out;
      nxt_oe_n = ~gpio_drive;
    end
    // no clock edges reach the core when off
    nxt_crise = clk_rise & link_en;
    nxt_cfall = clk_fall & link_en;
  end

  // register pin and feed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dio_out_ff <= 1'h0;
      oe_n_ff <= 1'h1;
      crise_ff <= 1'h0;
      cfall_ff <= 1'h0;
    end else begin
      dio_out_ff <= nxt_dio_out;
      oe_n_ff <= nxt_oe_n;
      crise_ff <= nxt_crise;
      cfall_ff <= nxt_cfall;
    end
  end

  assign swdio_out = dio_out_ff;
  assign swdio_oe_n = oe_n_ff;
  assign dbg_clk_rise = crise_ff;
  assign dbg_clk_fall = cfall_ff;
  // data input held low to the core while the link is off
  assign dbg_dio_in = dio_lvl & link_en;
  assign dbg_link_en = link_en;
  // gpio reads the pin as seen; while owned it reads debug traffic
  assign gpio_in = dio_lvl;

  // ****************************************************************
  // freeze control
  // ****************************************************************
  dsc_freeze_t frz_ff;  // registered freeze levels
  dsc_freeze_t nxt_frz;

  // next freeze levels
  always_comb begin
    // timers stop while core_flag_a under debug
    nxt_frz.timer = owned & core_flag_a & timer_freeze_enable;
    // comm units stop while core_flag_a under debug
    nxt_frz.comm = owned & core_flag_a & comm_freeze_enable;
  end

  // register freeze levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frz_ff <= '0;
    end else begin
      frz_ff <= nxt_frz;
    end
  end

  assign freeze_o = frz_ff;

  // ****************************************************************
  // status word
  // ****************************************************************
  always_comb begin
    stat_w = 32'h00000000;
    stat_w[`DSC_ST_LINK_BIT] = link_en;
    stat_w[`DSC_ST_ATT_BIT] = owned;
    stat_w[`DSC_ST_TFRZ_BIT] = frz_ff.timer;
    stat_w[`DSC_ST_CFRZ_BIT] = frz_ff.comm;
    stat_w[`DSC_ST_CLK_BIT] = clk_lvl;
  end

endmodule : dsc_top

`default_nettype wire

// File: test/dsc_monitor.sv
// checker of dsc_top port behaviour over time
// assumes it is bound to every dsc_top instance
`default_nettype none
module dsc_monitor
  import dsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic gpio_out,
  input wire logic gpio_drive,
  input wire logic swdio_out,
  input wire logic swdio_oe_n,
  input wire logic dbg_clk_rise,
  input wire logic dbg_clk_fall,
  input wire logic dbg_dio_in,
  input wire logic dbg_link_en,
  input wire logic core_flag_a,
  input wire logic deep_sleep,
  input wire dsc_freeze_t freeze_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, reset masks every check
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_ack_next: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
  a_sleep_off: assert property (deep_sleep |-> !dbg_link_en)
    else $error("link enabled in deep sleep");
  a_gpio_owns: assert property (!$past(dbg_link_en) |->
    swdio_out == $past(gpio_out) && swdio_oe_n == !$past(gpio_drive))
    else $error("data pin not under port control");
  a_dio_quiet: assert property (!dbg_link_en |-> !dbg_dio_in)
    else $error("data input seen while link off");
  a_edge_drop: assert property (!$past(dbg_link_en) |->
    !dbg_clk_rise && !dbg_clk_fall)
    else $error("clock edge passed while link off");
  a_halt_only: assert property
    (!$past(core_flag_a) |-> freeze_o == 2'h0)
    else $error("freeze without core_flag_a core");
  a_off_nofrz: assert property
    (!$past(dbg_link_en) |-> freeze_o == 2'h0)
    else $error("freeze while link off");
  a_rise_once: assert property (dbg_clk_rise |=> !dbg_clk_rise)
    else $error("rise pulse longer than one cycle");
endmodule : dsc_monitor
bind dsc_top dsc_monitor i_mon (.mclk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .gpio_out, .gpio_drive, .swdio_out, .swdio_oe_n,
  .dbg_clk_rise, .dbg_clk_fall, .dbg_dio_in, .dbg_link_en,
  .core_flag_a, .deep_sleep, .freeze_o);
`default_nettype wire

// File: test/dsc_probe.sv
// behavioural debug probe on the clock and data pins
// assumes the bench calls frame to clock bits; clock idles low
`default_nettype none
module dsc_probe (
  output logic swclk,
  output logic swdio
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    swclk = 1'h0;
    swdio = 1'h1;
  end
  // two pins only; bench frames also in deep sleep and with the port disabled
  task automatic frame(input int n);
    #3;
    for (int i = 0; i < n; i++) begin
      swdio = i[0];
      #40 swclk = 1'h1;
      #40 swclk = 1'h0;
    end
    // released line: show inverse, not the last bit
    swdio = ~swdio;
  endtask : frame
endmodule : dsc_probe
`default_nettype wire

// File: test/dsc_top_tb.sv
// self-checking bench for dsc_top
// assumes dsc_probe drives the link pins; bench drives the rest
`default_nettype none
module dsc_top_tb
  import dsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0;
  dsc_wb_req_t wb_req_i = '0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, swclk_pin, swdio_in, swdio_out, swdio_oe_n;
  logic dbg_attached = 0, dbg_dio_out = 0, dbg_dio_drive = 0;
  logic gpio_out = 0, gpio_drive = 0, gpio_in;
  logic core_flag_a = 0, deep_sleep = 0;
  logic dbg_clk_rise, dbg_clk_fall, dbg_dio_in, dbg_link_en;
  dsc_freeze_t freeze_o;
  int fail_count = 0, checks = 0, edges = 0, base, cyc_n = 0;
  always #4 mclk = ~mclk;
  dsc_top i_dut (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_req_i,
    .wb_dat_o, .wb_ack_o, .swclk_pin, .swdio_in, .swdio_out,
    .swdio_oe_n, .dbg_attached, .dbg_dio_out, .dbg_dio_drive,
    .dbg_clk_rise, .dbg_clk_fall, .dbg_dio_in, .dbg_link_en,
    .gpio_out, .gpio_drive, .gpio_in, .core_flag_a, .deep_sleep,
    .freeze_o);
  dsc_probe i_probe (.swclk(swclk_pin), .swdio(swdio_in));
  // count link clock edges the block reports
  always @(posedge mclk) edges <= edges + dbg_clk_rise + dbg_clk_fall;
  // ******************
  // tasks
  // ******************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; waits for ack, no fixed latency assumed
  task automatic xfer(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic w);
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_req_i <= '{a, d, s, w};
    do @(posedge mclk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : xfer
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic link(input int n);
    base = edges;
    i_probe.frame(n);
    tick(10);
  endtask : link
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // hang guard, far above the few hundred cycles used
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n > 5000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    tick(12);
    rst <= 1'h0;
    xfer(8'h00, 32'h0, 4'h0, 1'h0);
    chk(q, 32'h0);
    xfer(8'h00, 32'hFFFFFFFF, 4'hF, 1'h1);
    xfer(8'h00, 32'h0, 4'h6, 1'h1);
    xfer(8'h00, 32'h0, 4'h0, 1'h0);
    chk(q, 32'h01000003);
    xfer(8'h00, 32'h0, 4'hF, 1'h1);
    xfer(8'h08, 32'hFFFFFFFF, 4'hF, 1'h1);
    xfer(8'h08, 32'h0, 4'h0, 1'h0);
    chk(q, 32'h0);
    xfer(8'h04, 32'hFFFFFFFF, 4'hF, 1'h1);
    xfer(8'h04, 32'h0, 4'h0, 1'h0);
    chk(q, 32'h1);
    dbg_attached <= 1'h1;
    dbg_dio_drive <= 1'h1;
    gpio_out <= 1'h1;
    tick(4);
    chk({swdio_oe_n, swdio_out}, 32'h0);
    // probe idles the data line high, so the core must see a one
    chk(dbg_dio_in, 32'h1);
    link(8);
    chk(edges - base, 32'h10);
    xfer(8'h00, 32'h3, 4'hF, 1'h1);
    core_flag_a <= 1'h1;
    tick(4);
    chk(freeze_o, 32'h3);
    // status: link on, owned, both freezes, serial clock low
    xfer(8'h04, 32'h0, 4'h0, 1'h0);
    chk(q, 32'hF);
    xfer(8'h00, 32'h1, 4'hF, 1'h1);
    tick(3);
    chk(freeze_o, 32'h2);
    xfer(8'h00, 32'h2, 4'hF, 1'h1);
    tick(3);
    chk(freeze_o, 32'h1);
    deep_sleep <= 1'h1;
    tick(3);
    chk(dbg_link_en, 32'h0);
    link(4);
    chk(edges - base, 32'h0);
    deep_sleep <= 1'h0;
    core_flag_a <= 1'h0;
    xfer(8'h00, 32'h01000000, 4'h8, 1'h1);
    tick(4);
    chk({swdio_oe_n, swdio_out}, 32'h3);
    chk(gpio_in, swdio_in);
    link(4);
    chk(edges - base, 32'h0);
    // second reset in mid-run: the disable bit must clear again
    rst <= 1'h1;
    tick(2);
    rst <= 1'h0;
    tick(1);
    chk(dbg_link_en, 32'h1);
    xfer(8'h00, 32'h0, 4'h0, 1'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule : dsc_top_tb
`default_nettype wire
